// >>> hdl/rtc_control_status.v
// control, status, aging trim and temperature registers of the rtc with its output pins
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"

// Operation
// - output select zero drives the square wave onto the shared pin
// - output select one lets enabled alarm matches activate the shared pin
// - alarm match always sets its flag whatever output select holds
// - output select is one after power-on
// - alarm two enable gates its flag to pin only in alarm mode, resets zero
// - alarm one enable gates its flag to pin only in alarm mode, resets zero
// - oscillator stop flag sets whenever oscillator stops, powers up at one
// - oscillator stop flag stays set until software writes zero
// - clock output enable gives 32.768khz while running, else high impedance; resets one
// - busy rises at conversion start, falls when compensation returns idle
// - alarm two match sets flag bit 1, asserts pin when enabled and output select is one
// - alarm one match sets flag bit 0, asserts pin when enabled and output select is one
// - writing zero clears an alarm flag, writing one leaves it
// - aging trim is signed two's complement, bit 7 sign, one capacitor per step
// - trim added on periodic conversion with changed temperature and every manual one
// - positive trim adds capacitance, negative removes it
// - temperature split: upper byte sign and integer, lower bits 7:6 fraction
// - 10-bit quarter-degree temperature refreshed per conversion, read only
// - convert bit starts conversion, held until done, cleared one cycle after busy falls
module rtc_control_status (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_rvalid_o,
  input  wire        alarm_one_match_i,
  input  wire        alarm_two_match_i,
  input  wire        on_backup_i,
  input  wire        osc_fail_i,
  input  wire [9:0]  temp_sample_i,
  input  wire [7:0]  cap_base_i,
  output wire        irq_or_square_wave_pin_o,
  output wire        irq_or_square_wave_pin_oe_o,
  output wire        clock_output_pin_o,
  output wire        clock_output_pin_oe_o,
  output wire [7:0]  cap_code_o,
  output wire        osc_running_o
);

  // control register fields
  reg        oscillator_disable_on_backup;
  reg        backup_square_wave_enable;
  reg        convert_request;
  reg        rate_select_high;
  reg        rate_select_low;
  reg        output_select;
  reg        alarm_two_irq_enable;
  reg        alarm_one_irq_enable;

  // status register fields
  reg        oscillator_stop_flag;
  reg        clock_output_enable;
  reg        alarm_two_flag;
  reg        alarm_one_flag;

  reg  [7:0] aging_trim;

  // pin synchronisers
  reg        backup_meta;
  reg        backup_sync;
  reg        fail_meta;
  reg        fail_sync;

  // 32.768khz divider chain
  reg  [`CHAIN_BITS-1:0] chain;
  reg  [5:0]             seconds;
  reg                    periodic_start;
  reg                    square_wave;

  wire       osc_running;
  wire       clk32;
  wire       clk32_rise;
  wire       compensation_busy;
  wire       manual_done;
  wire [9:0] temperature;
  wire       wr_control;
  wire       wr_status;
  wire       wr_aging;
  wire       irq_active;
  wire       sqw_allowed;
  wire [7:0] control_settings;
  wire [7:0] status_flags;
  wire [7:0] temperature_upper;
  wire [7:0] temperature_lower;
  wire [5:0] period_last;
  wire [31:0] period_full;

  assign wr_control = reg_wr_i && (reg_addr_i == `REG_CONTROL);
  assign wr_status  = reg_wr_i && (reg_addr_i == `REG_STATUS);
  assign wr_aging   = reg_wr_i && (reg_addr_i == `REG_AGING);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      backup_meta <= 1'b0;
      backup_sync <= 1'b0;
      fail_meta   <= 1'b0;
      fail_sync   <= 1'b0;
    end else begin
      backup_meta <= on_backup_i;
      backup_sync <= backup_meta;
      fail_meta   <= osc_fail_i;
      fail_sync   <= fail_meta;
    end
  end

  // the oscillator halts on a fault, or on backup supply when disabled there
  assign osc_running   = !fail_sync && !(oscillator_disable_on_backup && backup_sync);
  assign osc_running_o = osc_running;

  clock_nco u_nco (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (osc_running),
    .clk32_o  (clk32),
    .rise_o   (clk32_rise)
  );

  // binary chain of 32.768khz cycles feeds every square-wave rate and the seconds
  assign period_full = `PERIOD_SECONDS - 1;
  assign period_last = period_full[5:0];

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chain          <= {`CHAIN_BITS{1'b0}};
      seconds        <= 6'h00;
      periodic_start <= 1'b0;
    end else begin
      periodic_start <= 1'b0;
      if (clk32_rise) begin
        chain <= chain + {{(`CHAIN_BITS-1){1'b0}}, 1'b1};
        if (&chain) begin
          if (seconds == period_last) begin
            seconds        <= 6'h00;
            periodic_start <= 1'b1;
          end else begin
            seconds <= seconds + 6'h01;
          end
        end
      end
    end
  end

  always @* begin
    case ({rate_select_high, rate_select_low})
      2'b00:   square_wave = chain[14];
      2'b01:   square_wave = chain[4];
      2'b10:   square_wave = chain[2];
      2'b11:   square_wave = chain[1];
      default: square_wave = chain[14];
    endcase
  end

  // control register; a write of zero to convert is always ignored, only completion clears it
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oscillator_disable_on_backup <= 1'b0;
      backup_square_wave_enable    <= 1'b0;
      convert_request              <= 1'b0;
      rate_select_high             <= 1'b1;
      rate_select_low              <= 1'b1;
      output_select                <= 1'b1;
      alarm_two_irq_enable         <= 1'b0;
      alarm_one_irq_enable         <= 1'b0;
    end else begin
      if (wr_control) begin
        oscillator_disable_on_backup <= reg_wdata_i[`CTL_OSC_DISABLE];
        backup_square_wave_enable    <= reg_wdata_i[`CTL_BACKUP_SQW];
        rate_select_high             <= reg_wdata_i[`CTL_RATE_HIGH];
        rate_select_low              <= reg_wdata_i[`CTL_RATE_LOW];
        output_select                <= reg_wdata_i[`CTL_OUTPUT_SELECT];
        alarm_two_irq_enable         <= reg_wdata_i[`CTL_A2_IRQ_EN];
        alarm_one_irq_enable         <= reg_wdata_i[`CTL_A1_IRQ_EN];
      end
      // a new request wins over the completion of an older one
      if (wr_control && reg_wdata_i[`CTL_CONVERT])
        convert_request <= 1'b1;
      else if (manual_done)
        convert_request <= 1'b0;
    end
  end

  // status flags: hardware set wins over a software clear in the same cycle
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oscillator_stop_flag <= `STATUS_FLAG_RESET;
      clock_output_enable  <= `CLK_OUT_EN_RESET;
      alarm_two_flag       <= 1'b0;
      alarm_one_flag       <= 1'b0;
    end else begin
      if (!osc_running)
        oscillator_stop_flag <= 1'b1;
      else if (wr_status && !reg_wdata_i[`STS_OSC_STOP])
        oscillator_stop_flag <= 1'b0;
      if (wr_status)
        clock_output_enable <= reg_wdata_i[`STS_CLK_OUT_EN];
      if (alarm_two_match_i)
        alarm_two_flag <= 1'b1;
      else if (wr_status && !reg_wdata_i[`STS_A2_FLAG])
        alarm_two_flag <= 1'b0;
      if (alarm_one_match_i)
        alarm_one_flag <= 1'b1;
      else if (wr_status && !reg_wdata_i[`STS_A1_FLAG])
        alarm_one_flag <= 1'b0;
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      aging_trim <= `AGING_RESET;
    else if (wr_aging)
      aging_trim <= reg_wdata_i;
  end

  temp_conversion u_convert_request (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .periodic_i    (periodic_start),
    .manual_i      (convert_request),
    .aging_i       (aging_trim),
    .temp_sample_i (temp_sample_i),
    .cap_base_i    (cap_base_i),
    .busy_o        (compensation_busy),
    .manual_done_o (manual_done),
    .temp_o        (temperature),
    .cap_code_o    (cap_code_o)
  );

  assign control_settings = {oscillator_disable_on_backup, backup_square_wave_enable,
                             convert_request, rate_select_high, rate_select_low,
                             output_select, alarm_two_irq_enable, alarm_one_irq_enable};
  assign status_flags = {oscillator_stop_flag, 3'b000, clock_output_enable,
                         compensation_busy, alarm_two_flag, alarm_one_flag};
  assign temperature_upper = temperature[9:2];
  assign temperature_lower = {temperature[1:0], 6'b000000};

  // read data is registered one cycle after the strobe; unmapped offsets read zero
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `REG_CONTROL:    reg_rdata_o <= control_settings;
          `REG_STATUS:     reg_rdata_o <= status_flags;
          `REG_AGING:      reg_rdata_o <= aging_trim;
          `REG_TEMP_UPPER: reg_rdata_o <= temperature_upper;
          `REG_TEMP_LOWER: reg_rdata_o <= temperature_lower;
          default:         reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // shared pin is open drain and active low in alarm mode
  assign irq_active = (alarm_one_flag && alarm_one_irq_enable) ||
                      (alarm_two_flag && alarm_two_irq_enable);
  // on backup supply the square wave needs its own enable, otherwise the pin floats
  assign sqw_allowed = osc_running && (!backup_sync || backup_square_wave_enable);
  assign irq_or_square_wave_pin_o  = 1'b0;
  assign irq_or_square_wave_pin_oe_o = output_select ? irq_active
                                                     : (sqw_allowed && !square_wave);

  // clock_output_pin pin is open drain too, released whenever disabled or stopped
  assign clock_output_pin_o  = 1'b0;
  assign clock_output_pin_oe_o = clock_output_enable && osc_running && !clk32;

endmodule // rtc_control_status

`default_nettype wire

// >>> include/rtc_defs.vh
// register offsets, field positions, reset values and timing counts of the rtc control block
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

`define REG_CONTROL        8'h0e
`define REG_STATUS         8'h0f
`define REG_AGING          8'h10
`define REG_TEMP_UPPER     8'h11
`define REG_TEMP_LOWER     8'h12

`define CTL_OSC_DISABLE    7
`define CTL_BACKUP_SQW     6
`define CTL_CONVERT        5
`define CTL_RATE_HIGH      4
`define CTL_RATE_LOW       3
`define CTL_OUTPUT_SELECT  2
`define CTL_A2_IRQ_EN      1
`define CTL_A1_IRQ_EN      0

`define STS_OSC_STOP       7
`define STS_CLK_OUT_EN     3
`define STS_BUSY           2
`define STS_A2_FLAG        1
`define STS_A1_FLAG        0

`define CONTROL_RESET      8'h1c
`define STATUS_FLAG_RESET  1'b1
`define CLK_OUT_EN_RESET   1'b1
`define AGING_RESET        8'h00
`define TEMP_RESET         10'h000

`define CLK_HZ             20000000
`define CLKOUT_HZ          32768
`define NCO_BITS           24
`define NCO_INC            ((((64'd2 * `CLKOUT_HZ) << `NCO_BITS) + (`CLK_HZ / 2)) / `CLK_HZ)
`define CHAIN_BITS         15
`define PERIOD_SECONDS     64
`define CONVERT_REQUEST_TIME_US       200
`define CONVERT_REQUEST_CYCLES        ((`CONVERT_REQUEST_TIME_US * (`CLK_HZ / 1000000)))

`endif

// >>> hdl/clock_nco.v
// phase accumulator making the 32.768khz clock from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"

module clock_nco (
  input  wire                  clk_i,
  input  wire                  arst_n_i,
  input  wire                  run_i,
  output reg                   clk32_o,
  output reg                   rise_o
);

  wire [63:0]           inc_full;
  wire [`NCO_BITS:0]    next_acc;
  reg  [`NCO_BITS-1:0]  acc;

  assign inc_full = `NCO_INC;
  // carry out marks a half period; jitter of one system clock is accepted for low cost
  assign next_acc = {1'b0, acc} + {1'b0, inc_full[`NCO_BITS-1:0]};

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc     <= {`NCO_BITS{1'b0}};
      clk32_o <= 1'b0;
      rise_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      if (run_i) begin
        acc <= next_acc[`NCO_BITS-1:0];
        if (next_acc[`NCO_BITS]) begin
          clk32_o <= ~clk32_o;
          rise_o  <= ~clk32_o;
        end
      end
    end
  end

endmodule // clock_nco

`default_nettype wire

// >>> hdl/temp_conversion.v
// temperature conversion sequencer with aging trim applied to the capacitance code
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"

module temp_conversion (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        periodic_i,
  input  wire        manual_i,
  input  wire [7:0]  aging_i,
  input  wire [9:0]  temp_sample_i,
  input  wire [7:0]  cap_base_i,
  output reg         busy_o,
  output reg         manual_done_o,
  output reg  [9:0]  temp_o,
  output reg  [7:0]  cap_code_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONVERT_REQUEST = 1'b1;

  reg         state;
  reg         periodic_pending;
  reg         is_manual;
  reg  [12:0] cnt;
  wire [31:0] convert_request_full;
  wire        manual_start;
  wire [8:0]  sum;

  assign convert_request_full = `CONVERT_REQUEST_CYCLES;
  assign sum = {1'b0, cap_base_i} + {aging_i[7], aging_i};
  // the request bit drops one cycle after done, so that cycle must not restart a conversion
  assign manual_start = manual_i && !manual_done_o;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state            <= ST_IDLE;
      periodic_pending <= 1'b1;
      is_manual        <= 1'b0;
      cnt              <= 13'h0000;
      busy_o           <= 1'b0;
      manual_done_o    <= 1'b0;
      temp_o           <= `TEMP_RESET;
      cap_code_o       <= 8'h00;
    end else begin
      manual_done_o <= 1'b0;
      if (periodic_i)
        periodic_pending <= 1'b1;
      case (state)
        ST_IDLE: begin
          // a manual request arriving while busy waits here, it is never dropped
          if (manual_start || periodic_pending) begin
            state     <= ST_CONVERT_REQUEST;
            is_manual <= manual_start;
            busy_o    <= 1'b1;
            cnt       <= convert_request_full[12:0] - 13'h0001;
            if (!manual_start)
              periodic_pending <= periodic_i;
          end
        end
        ST_CONVERT_REQUEST: begin
          if (cnt == 13'h0000) begin
            state  <= ST_IDLE;
            busy_o <= 1'b0;
            temp_o <= temp_sample_i;
            manual_done_o <= is_manual;
            if (is_manual || (temp_sample_i != temp_o)) begin
              // positive trim adds capacitance, saturating at the array ends
              if (!aging_i[7] && sum[8])
                cap_code_o <= 8'hff;
              else if (aging_i[7] && sum[8])
                cap_code_o <= 8'h00;
              else
                cap_code_o <= sum[7:0];
            end
          end else begin
            cnt <= cnt - 13'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // temp_conversion

`default_nettype wire

// >>> sim/rtc_host_model.sv
// register bus master model issuing single byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  input  wire logic       clk_i,
  output var  logic       reg_wr_o,
  output var  logic       reg_rd_o,
  output var  logic [7:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // after the strobe the bus shows inverted values so a late sample is caught
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q, output logic ok);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    ok = reg_rvalid_i;
    q = reg_rdata_i;
  endtask
endmodule // rtc_host_model
`default_nettype wire

// >>> sim/rtc_control_status_monitor.sv
// concurrent checks on the rtc control block ports
`timescale 1ns/1ps
`default_nettype none
module rtc_control_status_monitor (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       alarm_one_match_i,
  input wire logic       osc_fail_i,
  input wire logic       osc_running_o,
  input wire logic       clock_output_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence read_of(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence clear_one;
    reg_wr_i && reg_addr_i == 8'h0f && !reg_wdata_i[0] && !alarm_one_match_i;
  endsequence
  sequence aging_write;
    reg_wr_i && reg_addr_i == 8'h10;
  endsequence
  chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  chk_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read answer without request");
  chk_alarm_sets_flag: assert property (
    alarm_one_match_i ##1 !reg_wr_i ##1 read_of(8'h0f) |=> reg_rdata_o[0])
    else $error("alarm one flag not set by match");
  chk_flag_write_clear: assert property (
    clear_one ##1 !alarm_one_match_i ##1 read_of(8'h0f) |=> !reg_rdata_o[0])
    else $error("alarm one flag not cleared");
  chk_status_unused_zero: assert property (
    reg_rvalid_o && $past(reg_addr_i) == 8'h0f |-> reg_rdata_o[6:4] == 3'b000)
    else $error("unused status bits not zero");
  chk_temp_low_zero: assert property (
    reg_rvalid_o && $past(reg_addr_i) == 8'h12 |-> reg_rdata_o[5:0] == 6'h00)
    else $error("temperature lower byte low bits not zero");
  chk_aging_readback: assert property (
    aging_write ##2 read_of(8'h10) |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("aging trim readback differs");
  chk_unmapped_zero: assert property (
    reg_rd_i && (reg_addr_i < 8'h0e || reg_addr_i > 8'h12) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_osc_stop_seen: assert property (osc_fail_i [*3] |-> !osc_running_o)
    else $error("oscillator failure not seen");
  chk_clock_pin_frozen: assert property (
    !osc_running_o [*3] |-> $stable(clock_output_pin_oe_o))
    else $error("clock pin moves while oscillator stopped");
endmodule // rtc_control_status_monitor
bind rtc_control_status rtc_control_status_monitor mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .alarm_one_match_i(alarm_one_match_i), .osc_fail_i(osc_fail_i),
  .osc_running_o(osc_running_o), .clock_output_pin_oe_o(clock_output_pin_oe_o));
`default_nettype wire

// >>> sim/rtc_control_status_bench.sv
// self-checking bench for the rtc control, status and trim block
`timescale 1ns/1ps
`default_nettype none
module rtc_control_status_bench;
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       m1 = 1'b0;
  logic       m2 = 1'b0;
  logic       fail = 1'b0;
  logic [9:0] temp = 10'h000;
  logic [7:0] base = 8'h90;
  wire logic       wr, rd, rvalid, irq, irq_oe, ck, ck_oe, run;
  wire logic [7:0] addr, wdata, rdata, cap;
  int fail_count = 0;
  int num_checks = 0;
  always #25 clk_i = ~clk_i;
  rtc_host_model host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  rtc_control_status uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .alarm_one_match_i(m1), .alarm_two_match_i(m2), .on_backup_i(1'b0), .osc_fail_i(fail),
    .temp_sample_i(temp), .cap_base_i(base), .irq_or_square_wave_pin_o(irq),
    .irq_or_square_wave_pin_oe_o(irq_oe), .clock_output_pin_o(ck),
    .clock_output_pin_oe_o(ck_oe), .cap_code_o(cap), .osc_running_o(run));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic ok;
    host.read_reg(a, q, ok);
    check("read valid", 1'b1, ok);
    check($sformatf("reg %h", a), exp, q);
  endtask
  task automatic reset_values;
    rd_chk(8'h0e, 8'h1c);
    rd_chk(8'h0f, 8'h8c);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h12, 8'h00);
    rd_chk(8'h10, 8'h00);
  endtask
  task automatic access_kinds;
    host.write_reg(8'h10, 8'h80);
    rd_chk(8'h10, 8'h80);
    host.write_reg(8'h11, 8'hff);
    host.write_reg(8'h0f, 8'hfc);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h0f, 8'h8c);
    rd_chk(8'h20, 8'h00);
  endtask
  // software polls busy before starting another conversion
  task automatic wait_idle;
    logic [7:0] q;
    logic ok;
    int n;
    n = 0;
    do begin
      host.read_reg(8'h0f, q, ok);
      n++;
    end while (q[2] !== 1'b0 && n < 3000);
    check("busy", 1'b0, q[2]);
  endtask
  task automatic conversion(input logic [9:0] t, input logic [7:0] trim, input logic [7:0] c);
    wait_idle();
    @(posedge clk_i);
    temp <= t;
    host.write_reg(8'h10, trim);
    host.write_reg(8'h0e, 8'h3c);
    rd_chk(8'h0e, 8'h3c);
    wait_idle();
    rd_chk(8'h0e, 8'h1c);
    rd_chk(8'h11, t[9:2]);
    rd_chk(8'h12, {t[1:0], 6'h00});
    check("cap code", c, cap);
  endtask
  task automatic alarms;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      m1 <= (i == 0);
      m2 <= (i == 1);
      @(posedge clk_i);
      m1 <= 1'b0;
      m2 <= 1'b0;
      rd_chk(8'h0f, 8'h88 | (8'h01 << i));
      check("irq masked", 1'b0, irq_oe);
      host.write_reg(8'h0e, 8'h1c | (8'h01 << i));
      @(negedge clk_i);
      check("irq raised", 1'b1, irq_oe);
      host.write_reg(8'h0f, 8'h8b);
      rd_chk(8'h0f, 8'h88 | (8'h01 << i));
      host.write_reg(8'h0f, 8'h88);
      rd_chk(8'h0f, 8'h88);
      check("irq cleared", 1'b0, irq_oe);
      host.write_reg(8'h0e, 8'h1c);
    end
  endtask
  // cycles between two rises of a pin enable, zero if fewer than two rises within the limit
  task automatic period(input logic sel, input int lim, output int cyc);
    logic prev, cur;
    int n, seen;
    prev = 1'b1;
    n = 0;
    seen = 0;
    while (seen < 2 && n < lim) begin
      @(posedge clk_i);
      cur = sel ? ck_oe : irq_oe;
      n++;
      if (cur === 1'b1 && prev === 1'b0) begin
        seen++;
        if (seen == 1) n = 0;
      end
      prev = cur;
    end
    cyc = (seen == 2) ? n : 0;
  endtask
  task automatic square_rates;
    int cyc, p;
    for (int r = 1; r < 4; r++) begin
      host.write_reg(8'h0e, {3'b000, r[1:0], 3'b000});
      p = 20000000 / ((r == 1) ? 1024 : (r == 2) ? 4096 : 8192);
      period(1'b0, 45000, cyc);
      check("square period", 1'b1, cyc > p - p / 50 && cyc < p + p / 50);
    end
    host.write_reg(8'h0e, 8'h1c);
  endtask
  task automatic clock_output;
    int cyc;
    period(1'b1, 2000, cyc);
    check("clk32 period", 1'b1, cyc >= 609 && cyc <= 612);
    host.write_reg(8'h0f, 8'h80);
    period(1'b1, 1500, cyc);
    check("clk32 off", 0, cyc);
    check("clk32 released", 1'b0, ck_oe);
    host.write_reg(8'h0f, 8'h08);
    rd_chk(8'h0f, 8'h08);
    @(posedge clk_i);
    fail <= 1'b1;
    repeat (10) @(posedge clk_i);
    fail <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(8'h0f, 8'h88);
    rd_chk(8'h0f, 8'h88);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    reset_values();
    access_kinds();
    conversion(10'h065, 8'h05, 8'h95);
    conversion(10'h3fe, 8'hfb, 8'h8b);
    alarms();
    square_rates();
    clock_output();
    complete_run();
  end
  // three conversions, up to two square periods per rate, plus margin
  initial begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
endmodule // rtc_control_status_bench
`default_nettype wire
